// file: rtl/mcw_pkg.sv
// Shared constants of the arithmetic and wait execution block.
// Assumes a 16-bit instruction word and one core clock domain.
package mcw_pkg;
    localparam int DATA_W = 16;
    localparam int SEL_W = 3;
    localparam int NUM_REGS = 8;
    localparam int PC_W = 10;
    localparam int WT_ROWS = 5;
    localparam int COND_SEL_W = 4;
    localparam int NUM_CONDS = 16;
    localparam int ADDR_W = 8;

    // Opcode patterns, upper instruction bits
    localparam logic [10:0] OP_STSRB = 11'h1B8;
    localparam logic [5:0] OP_SUB = 6'h0A;
    localparam logic [5:0] OP_SUBI = 6'h07;
    localparam logic [12:0] OP_SWAP = 13'h06AC;
    localparam logic [12:0] OP_INT_TO_TWOS = 13'h06E6;
    localparam logic [11:0] OP_TOINT = 12'h372;
    localparam logic [10:0] OP_WAIT = 11'h1A8;

    // Field positions
    localparam int F_LEVEL = 4;
    localparam int F_SUB_MARK = 6;
    localparam int F_RST = 3;
    localparam int F_SRC1_LO = 0;
    localparam int F_SRC2_LO = 3;
    localparam int F_IMM_LO = 3;
    localparam int F_DST_LO = 7;

    // Condition flag positions
    localparam int FL_ZERO = 0;
    localparam int FL_NEG = 1;
    localparam int FL_UBORROW = 2;
    localparam int FL_UCARRY = 3;
    localparam int FL_SLOW = 4;
    localparam int FL_SHIGH = 5;
    localparam int FL_CS = 6;
    localparam int FLAGS_W = 7;

    // Register port map
    localparam logic [ADDR_W-1:0] A_ALU_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] A_FLAGS = 8'h09;
    localparam logic [ADDR_W-1:0] A_WAIT_STATE = 8'h0A;
    localparam logic [ADDR_W-1:0] A_WT_BASE = 8'h10;
    localparam int WT_DEST_LO = 4;

    // Reset values
    localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
    localparam logic [FLAGS_W-1:0] RST_FLAGS = 7'h00;
    localparam logic [PC_W-1:0] RST_PC = 10'h000;
endpackage

// file: rtl/mcw_sub_unit.sv
// 16-bit subtractor with the six arithmetic condition flags.
// Purely combinational; the caller registers result and flags together.
`timescale 1ns/1ps
module mcw_sub_unit (
    input wire logic [mcw_pkg::DATA_W-1:0] minuend,
    input wire logic [mcw_pkg::DATA_W-1:0] subtrahend,
    output logic [mcw_pkg::DATA_W-1:0] difference,
    output logic result_zero_flag,
    output logic result_negative_flag,
    output logic unsigned_borrow_flag,
    output logic unsigned_carry_flag,
    output logic signed_low_overflow_flag,
    output logic signed_high_overflow_flag
);
    logic [mcw_pkg::DATA_W:0] wide;
    logic sa;
    logic sb;
    logic sr;

    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        difference = wide[mcw_pkg::DATA_W-1:0];
        sa = minuend[mcw_pkg::DATA_W-1];
        sb = subtrahend[mcw_pkg::DATA_W-1];
        sr = difference[mcw_pkg::DATA_W-1];
        result_zero_flag = (difference == 16'h0000);
        result_negative_flag = sr;
        unsigned_borrow_flag = wide[mcw_pkg::DATA_W];
        // A difference of two unsigned words never exceeds the word
        unsigned_carry_flag = 1'b0;
        signed_low_overflow_flag = sa & ~sb & ~sr;
        signed_high_overflow_flag = ~sa & sb & sr;
    end
endmodule // mcw_sub_unit

// file: rtl/mcw_wait_table.sv
// Five-row wait table: condition select and jump destination per row.
// Rows are loaded through a write port; conditions are same-clock levels.
`timescale 1ns/1ps
module mcw_wait_table (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic row_we,
    input wire logic [2:0] row_sel,
    input wire logic [mcw_pkg::COND_SEL_W-1:0] row_cond,
    input wire logic [mcw_pkg::PC_W-1:0] row_dest,
    input wire logic [mcw_pkg::WT_ROWS-1:0] wait_row_enables,
    input wire logic [mcw_pkg::NUM_CONDS-1:0] wait_cond,
    output logic hit,
    output logic [mcw_pkg::PC_W-1:0] hit_dest
);
    logic [mcw_pkg::COND_SEL_W-1:0] cond_r [mcw_pkg::WT_ROWS];
    logic [mcw_pkg::PC_W-1:0] dest_r [mcw_pkg::WT_ROWS];
    logic [mcw_pkg::WT_ROWS-1:0] fire;

    for (genvar i = 0; i < mcw_pkg::WT_ROWS; i++) begin : g_row
        always_ff @(posedge clock) begin
            if (!rst_b) begin
                cond_r[i] <= 4'h0;
                dest_r[i] <= mcw_pkg::RST_PC;
            end else if (row_we && row_sel == 3'(i)) begin
                cond_r[i] <= row_cond;
                dest_r[i] <= row_dest;
            end
        end
        // Mask bit i enables row i+1
        assign fire[i] = wait_row_enables[i] & wait_cond[cond_r[i]];
    end

    // Lowest firing row wins
    always_comb begin
        hit = |fire;
        hit_dest = mcw_pkg::RST_PC;
        for (int i = mcw_pkg::WT_ROWS - 1; i >= 0; i--) begin
            if (fire[i]) begin
                hit_dest = dest_r[i];
            end
        end
    end
endmodule // mcw_wait_table

// file: rtl/mcw_core.sv
// Execute stage for status-bit, subtract, swap, conversion and wait instructions.
// Assumes one instruction offered per cycle with instr_valid; the program
// counter lives outside and obeys pc_hold and pc_load.
//
// Notes on behaviour
// - Set-status-bit writes the level operand into one status bit only.
// - Four-bit index picks status bit 0 through 15 in binary.
// - Set-status-bit matches bits 15..5; level in bit 4, index in 3..0.
// - Register subtract writes first source minus second source to destination.
// - Register subtract: top six bits 001010, bit 6 set, fields dst/src2/src1.
// - Both subtracts update zero, negative, and four overflow flags.
// - Immediate subtract removes a four-bit immediate from the source register.
// - Byte swap exchanges low and high bytes of one register.
// - To-twos with sign bit clear just clears the register MSB.
// - To-twos with sign bit set negates bits 14..0 and sets MSB.
// - To-integer keeps a register whose MSB is zero.
// - To-integer with MSB set writes negation of bits 14..0.
// - To-integer loads sign bit from old MSB, or XORs it when rst is 0.
// - To-integer matches bits 15..4; reset option in bit 3.
// - Wait holds the program counter until an enabled row fires, then jumps.
// - Each row keeps a condition and destination loaded beforehand.
// - A five-bit mask selects which rows take part in a wait.
// - Mask zero stalls forever; mask bit n enables row n+1.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module mcw_core (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_ready,
    input wire logic [mcw_pkg::NUM_CONDS-1:0] wait_cond,
    output logic pc_hold,
    output logic pc_load,
    output logic [mcw_pkg::PC_W-1:0] pc_load_value,
    output logic [mcw_pkg::DATA_W-1:0] status_word,
    input wire logic [mcw_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mcw_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [mcw_pkg::DATA_W-1:0] reg_rdata
);
    typedef enum logic {MCW_RUN, MCW_WAIT} mcw_state_t;

    mcw_state_t state_r;
    mcw_state_t state_nxt;
    logic [mcw_pkg::DATA_W-1:0] arith_register_set [mcw_pkg::NUM_REGS];
    logic [mcw_pkg::DATA_W-1:0] status_r;
    logic [mcw_pkg::FLAGS_W-1:0] flags_r;
    logic [mcw_pkg::WT_ROWS-1:0] wait_row_enables_r;
    logic pc_load_r;
    logic [mcw_pkg::PC_W-1:0] pc_dest_r;
    logic [mcw_pkg::DATA_W-1:0] rdata_r;

    logic take;
    logic is_stsrb;
    logic is_sub;
    logic is_subi;
    logic is_swap;
    logic is_int_to_twos_op;
    logic is_toint;
    logic is_wait;
    logic known;
    logic [3:0] status_bit_index;
    logic [mcw_pkg::SEL_W-1:0] dst_sel;
    logic [mcw_pkg::DATA_W-1:0] op_a;
    logic [mcw_pkg::DATA_W-1:0] op_b;
    logic [mcw_pkg::DATA_W-1:0] sub_res;
    logic [5:0] sub_flags;
    logic alu_we;
    logic [mcw_pkg::DATA_W-1:0] alu_wdata;
    logic [mcw_pkg::DATA_W-1:0] srb_keep_mask;
    logic [14:0] neg_low;
    logic hit;
    logic [mcw_pkg::PC_W-1:0] hit_dest;
    logic wt_we;
    logic [mcw_pkg::DATA_W-1:0] prev_a_r;
    logic [mcw_pkg::DATA_W-1:0] prev_status_r;

    // Decode
    always_comb begin
        take = instr_valid && (state_r == MCW_RUN);
        is_stsrb = (instr[15:5] == mcw_pkg::OP_STSRB);
        is_sub = (instr[15:10] == mcw_pkg::OP_SUB) && instr[mcw_pkg::F_SUB_MARK];
        is_subi = (instr[15:10] == mcw_pkg::OP_SUBI);
        is_swap = (instr[15:3] == mcw_pkg::OP_SWAP);
        is_int_to_twos_op = (instr[15:3] == mcw_pkg::OP_INT_TO_TWOS);
        is_toint = (instr[15:4] == mcw_pkg::OP_TOINT);
        is_wait = (instr[15:5] == mcw_pkg::OP_WAIT);
        known = is_stsrb | is_sub | is_subi | is_swap | is_int_to_twos_op | is_toint | is_wait;
        status_bit_index = instr[3:0];
        srb_keep_mask = ~(16'h0001 << status_bit_index);
    end

    // Operand selection
    always_comb begin
        op_a = arith_register_set[instr[mcw_pkg::F_SRC1_LO +: mcw_pkg::SEL_W]];
        op_b = arith_register_set[instr[mcw_pkg::F_SRC2_LO +: mcw_pkg::SEL_W]];
        dst_sel = instr[mcw_pkg::F_SRC1_LO +: mcw_pkg::SEL_W];
        if (is_sub || is_subi) begin
            dst_sel = instr[mcw_pkg::F_DST_LO +: mcw_pkg::SEL_W];
        end
        if (is_subi) begin
            op_b = {12'h000, instr[mcw_pkg::F_IMM_LO +: 4]};
        end
        neg_low = 15'(~op_a[14:0] + 15'h0001);
    end

    mcw_sub_unit u_sub (
        .minuend(op_a),
        .subtrahend(op_b),
        .difference(sub_res),
        .result_zero_flag(sub_flags[0]),
        .result_negative_flag(sub_flags[1]),
        .unsigned_borrow_flag(sub_flags[2]),
        .unsigned_carry_flag(sub_flags[3]),
        .signed_low_overflow_flag(sub_flags[4]),
        .signed_high_overflow_flag(sub_flags[5])
    );

    // Result selection
    always_comb begin
        alu_we = 1'b0;
        alu_wdata = op_a;
        if (take) begin
            if (is_sub || is_subi) begin
                alu_we = 1'b1;
                alu_wdata = sub_res;
            end else if (is_swap) begin
                alu_we = 1'b1;
                alu_wdata = {op_a[7:0], op_a[15:8]};
            end else if (is_int_to_twos_op) begin
                alu_we = 1'b1;
                if (flags_r[mcw_pkg::FL_CS]) begin
                    alu_wdata = {1'b1, neg_low};
                end else begin
                    alu_wdata = {1'b0, op_a[14:0]};
                end
            end else if (is_toint) begin
                alu_we = 1'b1;
                if (op_a[15]) begin
                    alu_wdata = {1'b0, neg_low};
                end else begin
                    alu_wdata = op_a;
                end
            end
        end
    end

    // Register set, instruction write wins over port write
    for (genvar i = 0; i < mcw_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge clock) begin
            if (!rst_b) begin
                arith_register_set[i] <= mcw_pkg::RST_WORD;
            end else if (alu_we && dst_sel == 3'(i)) begin
                arith_register_set[i] <= alu_wdata;
            end else if (reg_wr && reg_addr == mcw_pkg::A_ALU_BASE + 8'(i)) begin
                arith_register_set[i] <= reg_wdata;
            end
        end
    end

    // Status register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_r <= mcw_pkg::RST_WORD;
        end else if (take && is_stsrb) begin
            status_r[status_bit_index] <= instr[mcw_pkg::F_LEVEL];
        end else if (reg_wr && reg_addr == mcw_pkg::A_STATUS) begin
            status_r <= reg_wdata;
        end
    end

    // Condition flags and conversion sign
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flags_r <= mcw_pkg::RST_FLAGS;
        end else if (take && (is_sub || is_subi)) begin
            flags_r[5:0] <= sub_flags;
        end else if (take && is_toint) begin
            if (instr[mcw_pkg::F_RST]) begin
                flags_r[mcw_pkg::FL_CS] <= op_a[15];
            end else begin
                flags_r[mcw_pkg::FL_CS] <= flags_r[mcw_pkg::FL_CS] ^ op_a[15];
            end
        end
    end

    // Wait sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MCW_RUN: begin
                if (take && is_wait) begin
                    state_nxt = MCW_WAIT;
                end
            end
            MCW_WAIT: begin
                if (hit) begin
                    state_nxt = MCW_RUN;
                end
            end
            default: begin
                state_nxt = MCW_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_r <= MCW_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wait_row_enables_r <= 5'h00;
        end else if (take && is_wait) begin
            wait_row_enables_r <= instr[4:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pc_load_r <= 1'b0;
            pc_dest_r <= mcw_pkg::RST_PC;
        end else begin
            pc_load_r <= (state_r == MCW_WAIT) && hit;
            if ((state_r == MCW_WAIT) && hit) begin
                pc_dest_r <= hit_dest;
            end
        end
    end

    assign wt_we = reg_wr && (reg_addr >= mcw_pkg::A_WT_BASE) &&
        (reg_addr < mcw_pkg::A_WT_BASE + 8'(mcw_pkg::WT_ROWS));

    mcw_wait_table u_wt (
        .clock(clock),
        .rst_b(rst_b),
        .row_we(wt_we),
        .row_sel(3'(reg_addr - mcw_pkg::A_WT_BASE)),
        .row_cond(reg_wdata[3:0]),
        .row_dest(reg_wdata[mcw_pkg::WT_DEST_LO +: mcw_pkg::PC_W]),
        .wait_row_enables(wait_row_enables_r),
        .wait_cond(wait_cond),
        .hit(hit),
        .hit_dest(hit_dest)
    );

    // Register port read
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdata_r <= mcw_pkg::RST_WORD;
        end else if (reg_rd) begin
            if (reg_addr < mcw_pkg::A_ALU_BASE + 8'(mcw_pkg::NUM_REGS)) begin
                rdata_r <= arith_register_set[reg_addr[mcw_pkg::SEL_W-1:0]];
            end else if (reg_addr == mcw_pkg::A_STATUS) begin
                rdata_r <= status_r;
            end else if (reg_addr == mcw_pkg::A_FLAGS) begin
                rdata_r <= {9'h000, flags_r};
            end else if (reg_addr == mcw_pkg::A_WAIT_STATE) begin
                rdata_r <= {10'h000, (state_r == MCW_WAIT), wait_row_enables_r};
            end else begin
                rdata_r <= mcw_pkg::RST_WORD;
            end
        end
    end

    assign instr_ready = (state_r == MCW_RUN);
    assign pc_hold = (state_r == MCW_WAIT);
    assign pc_load = pc_load_r;
    assign pc_load_value = pc_dest_r;
    assign status_word = status_r;
    assign reg_rdata = rdata_r;

    // Checking helpers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prev_a_r <= mcw_pkg::RST_WORD;
            prev_status_r <= mcw_pkg::RST_WORD;
        end else begin
            prev_a_r <= op_a;
            prev_status_r <= status_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_srb_level: assert property (
        take && is_stsrb |=> status_r[$past(status_bit_index)] == $past(instr[4]))
        else $error("status bit not written with level");
    chk_srb_others: assert property (
        take && is_stsrb |=> ((status_r ^ prev_status_r) & $past(srb_keep_mask)) == 16'h0000)
        else $error("other status bits disturbed");
    chk_sub_result: assert property (
        take && (is_sub || is_subi) |=>
        arith_register_set[$past(dst_sel)] == 16'(prev_a_r - $past(op_b)))
        else $error("subtract result wrong");
    chk_sub_zero_flag: assert property (
        take && (is_sub || is_subi) |=>
        flags_r[mcw_pkg::FL_ZERO] == (arith_register_set[$past(dst_sel)] == 16'h0000) &&
        flags_r[mcw_pkg::FL_UBORROW] == (prev_a_r < $past(op_b)))
        else $error("subtract flags wrong");
    chk_swap_bytes: assert property (
        take && is_swap |=> arith_register_set[$past(dst_sel)] == {prev_a_r[7:0], prev_a_r[15:8]})
        else $error("byte swap wrong");
    chk_to_twos_clear: assert property (
        take && is_int_to_twos_op && !flags_r[mcw_pkg::FL_CS] |=>
        arith_register_set[$past(dst_sel)] == {1'b0, prev_a_r[14:0]})
        else $error("to-twos with clear sign wrong");
    chk_to_twos_set: assert property (
        take && is_int_to_twos_op && flags_r[mcw_pkg::FL_CS] |=>
        arith_register_set[$past(dst_sel)] == {1'b1, 15'(15'h0000 - prev_a_r[14:0])})
        else $error("to-twos with set sign wrong");
    chk_toint_negate: assert property (
        take && is_toint && op_a[15] |=>
        arith_register_set[$past(dst_sel)] == {1'b0, 15'(15'h0000 - prev_a_r[14:0])})
        else $error("to-integer negation wrong");
    chk_toint_keep: assert property (
        take && is_toint && !op_a[15] |=> arith_register_set[$past(dst_sel)] == prev_a_r)
        else $error("to-integer changed a positive value");
    chk_toint_sign: assert property (
        take && is_toint |=> flags_r[mcw_pkg::FL_CS] ==
        ($past(instr[3]) ? prev_a_r[15] : ($past(flags_r[mcw_pkg::FL_CS]) ^ prev_a_r[15])))
        else $error("conversion sign update wrong");
    chk_wait_jump: assert property (
        pc_hold && hit |=> pc_load && !pc_hold && pc_load_value == $past(hit_dest))
        else $error("wait did not jump to row destination");
    chk_wait_stall: assert property (
        pc_hold && wait_row_enables_r == 5'h00 |=> pc_hold && !pc_load)
        else $error("empty wait mask released the core");
    chk_unknown_quiet: assert property (
        take && !known && !reg_wr |=> $stable(status_r) && $stable(flags_r) && !pc_hold)
        else $error("unknown pattern changed state");

    cov_sub: cover property (take && is_sub ##1 flags_r[mcw_pkg::FL_UBORROW]);
    cov_wait_jump: cover property (take && is_wait ##[1:20] pc_load);
    cov_toint_neg: cover property (take && is_toint && op_a[15]);
    cov_stall: cover property (pc_hold && wait_row_enables_r == 5'h00);
endmodule // mcw_core

// file: testbench/mcw_core_tb.sv
// Self-checking bench for the status-bit, subtract, swap, conversion and wait execute block.
// Assumes mcw_pkg and mcw_core are compiled first; one 25 MHz core clock, bench drives all ports.
`timescale 1ns/1ps
module mcw_core_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic instr_ready;
    logic [mcw_pkg::NUM_CONDS-1:0] wait_cond = 16'h0000;
    logic pc_hold;
    logic pc_load;
    logic [mcw_pkg::PC_W-1:0] pc_load_value;
    logic [mcw_pkg::DATA_W-1:0] status_word;
    logic [mcw_pkg::ADDR_W-1:0] reg_addr = 8'h00;
    logic [mcw_pkg::DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [mcw_pkg::DATA_W-1:0] reg_rdata;
    int n_errors = 0;
    int n_checks = 0;

    always #20 clock = ~clock;

    mcw_core dut (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .wait_cond(wait_cond), .pc_hold(pc_hold), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .status_word(status_word), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Register port write and read, one strobe cycle each
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task rchk(input string name, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(name, v, exp);
    endtask

    // One instruction, results settled on return
    task exec(input logic [15:0] i);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= i;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask

    function automatic logic [15:0] flg(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] r;
        logic [15:0] f;
        r = a - b;
        f = 16'h0000;
        f[mcw_pkg::FL_ZERO] = (r == 16'h0000);
        f[mcw_pkg::FL_NEG] = r[15];
        f[mcw_pkg::FL_UBORROW] = (a < b);
        f[mcw_pkg::FL_SLOW] = a[15] & ~b[15] & ~r[15];
        f[mcw_pkg::FL_SHIGH] = ~a[15] & b[15] & r[15];
        return f;
    endfunction

    task t_status;
        logic [15:0] e;
        e = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            exec({mcw_pkg::OP_STSRB, 1'b1, 4'(k)});
            e[k] = 1'b1;
            chk("status_set", status_word, e);
        end
        exec({mcw_pkg::OP_STSRB, 1'b0, 4'h7});
        e[7] = 1'b0;
        chk("status_clr", status_word, e);
        rchk("status_rd", mcw_pkg::A_STATUS, e);
    endtask

    task arith(input logic [15:0] a, input logic [15:0] b, input logic imm_form);
        logic [15:0] v;
        wr(mcw_pkg::A_ALU_BASE + 8'h01, a);
        wr(mcw_pkg::A_ALU_BASE + 8'h02, imm_form ? ~b : b);
        if (imm_form) begin
            exec({mcw_pkg::OP_SUBI, 3'd4, b[3:0], 3'd1});
        end else begin
            exec({mcw_pkg::OP_SUB, 3'd4, 1'b1, 3'd2, 3'd1});
        end
        rchk("sub_result", mcw_pkg::A_ALU_BASE + 8'h04, a - b);
        rd(mcw_pkg::A_FLAGS, v);
        chk("sub_flags", v & 16'h003F, flg(a, b));
    endtask

    task conv(input logic [15:0] i, input logic [15:0] v0, input logic [15:0] ev, input logic ecs);
        logic [15:0] v;
        wr(mcw_pkg::A_ALU_BASE + 8'h06, v0);
        exec(i);
        rchk("conv_value", mcw_pkg::A_ALU_BASE + 8'h06, ev);
        rd(mcw_pkg::A_FLAGS, v);
        chk("conv_sign", 16'(v[mcw_pkg::FL_CS]), 16'(ecs));
    endtask

    task waitrun(input logic [4:0] mask, input logic [15:0] idle, input logic [15:0] fire,
                 input logic [9:0] dest);
        @(posedge clock);
        wait_cond <= idle;
        exec({mcw_pkg::OP_WAIT, mask});
        chk("wait_hold", 16'(pc_hold), 16'h0001);
        chk("wait_ready", 16'(instr_ready), 16'h0000);
        exec({mcw_pkg::OP_STSRB, 1'b1, 4'h7});
        chk("refused_status", 16'(status_word[7]), 16'h0000);
        chk("idle_hold", 16'(pc_hold), 16'h0001);
        chk("idle_load", 16'(pc_load), 16'h0000);
        rchk("wait_state", mcw_pkg::A_WAIT_STATE, {10'h000, 1'b1, mask});
        @(posedge clock);
        wait_cond <= fire;
        @(posedge clock);
        #1;
        chk("jump_load", 16'(pc_load), 16'h0001);
        chk("jump_dest", 16'(pc_load_value), 16'(dest));
        chk("jump_hold", 16'(pc_hold), 16'h0000);
        @(posedge clock);
        wait_cond <= 16'h0000;
        #1;
        chk("load_pulse", 16'(pc_load), 16'h0000);
    endtask

    task t_unknown;
        logic [15:0] r4;
        logic [15:0] fl;
        logic [15:0] st;
        rd(mcw_pkg::A_ALU_BASE + 8'h04, r4);
        rd(mcw_pkg::A_FLAGS, fl);
        st = status_word;
        exec(16'hFFFF);
        exec({mcw_pkg::OP_SUB, 3'd4, 1'b0, 3'd2, 3'd1});
        exec(16'h3580);
        rchk("unknown_reg", mcw_pkg::A_ALU_BASE + 8'h04, r4);
        rchk("unknown_flags", mcw_pkg::A_FLAGS, fl);
        chk("unknown_status", status_word, st);
        chk("unknown_hold", 16'(pc_hold), 16'h0000);
        rchk("unmapped_read", 8'h40, 16'h0000);
    endtask

    task t_stall;
        logic seen;
        seen = 1'b0;
        @(posedge clock);
        wait_cond <= 16'hFFFF;
        exec({mcw_pkg::OP_WAIT, 5'b00000});
        for (int c = 0; c < 20; c++) begin
            @(posedge clock);
            #1;
            seen = seen | pc_load | ~pc_hold;
        end
        chk("mask0_stall", 16'(seen), 16'h0000);
        @(posedge clock);
        rst_b <= 1'b0;
        wait_cond <= 16'h0000;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk("reset_hold", 16'(pc_hold), 16'h0000);
        chk("reset_ready", 16'(instr_ready), 16'h0001);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        t_status();
        arith(16'h0005, 16'h0005, 1'b0);
        arith(16'h0003, 16'h0005, 1'b0);
        arith(16'h8000, 16'h0001, 1'b0);
        arith(16'h7FFF, 16'hFFFF, 1'b0);
        arith(16'h0010, 16'h000F, 1'b1);
        arith(16'h0002, 16'h0009, 1'b1);
        wr(mcw_pkg::A_ALU_BASE + 8'h05, 16'h12AB);
        exec({mcw_pkg::OP_SWAP, 3'd5});
        rchk("swap", mcw_pkg::A_ALU_BASE + 8'h05, 16'hAB12);
        conv({mcw_pkg::OP_TOINT, 1'b1, 3'd6}, 16'h8005, 16'h7FFB, 1'b1);
        conv({mcw_pkg::OP_TOINT, 1'b0, 3'd6}, 16'h8001, 16'h7FFF, 1'b0);
        conv({mcw_pkg::OP_TOINT, 1'b0, 3'd6}, 16'h1234, 16'h1234, 1'b0);
        conv({mcw_pkg::OP_INT_TO_TWOS, 3'd6}, 16'hFFFF, 16'h7FFF, 1'b0);
        conv({mcw_pkg::OP_TOINT, 1'b0, 3'd6}, 16'h8000, 16'h0000, 1'b1);
        conv({mcw_pkg::OP_INT_TO_TWOS, 3'd6}, 16'h0003, 16'hFFFD, 1'b1);
        t_unknown();
        // Rows 1..5: destination in bits 13:4, condition index in bits 3:0
        wr(mcw_pkg::A_WT_BASE + 8'h00, {2'b00, 10'h011, 4'h2});
        wr(mcw_pkg::A_WT_BASE + 8'h01, {2'b00, 10'h022, 4'h8});
        wr(mcw_pkg::A_WT_BASE + 8'h02, {2'b00, 10'h033, 4'h5});
        wr(mcw_pkg::A_WT_BASE + 8'h03, {2'b00, 10'h044, 4'hA});
        wr(mcw_pkg::A_WT_BASE + 8'h04, {2'b00, 10'h155, 4'hF});
        waitrun(5'b00100, 16'h8504, 16'h0020, 10'h033);
        waitrun(5'b10001, 16'h0520, 16'h8004, 10'h011);
        waitrun(5'b10000, 16'h0524, 16'h8000, 10'h155);
        waitrun(5'b00010, 16'h8424, 16'h0100, 10'h022);
        waitrun(5'b01000, 16'h8124, 16'h0400, 10'h044);
        t_stall();
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        for (int c = 0; c < 20000; c++) begin
            @(posedge clock);
        end
        n_errors++;
        $display("timeout after 20000 cycles");
        give_verdict();
    end
endmodule // mcw_core_tb
